// file: common/dtl_map.vh
// Register map, field positions, reset values and pipeline timing for the
// dither / timestamp / link enable register bank.
// Assumes a byte-wide register port with 12-bit addresses.
`ifndef DTL_MAP_VH
`define DTL_MAP_VH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define DTL_AW             12
`define DTL_DW             8
`define DTL_CONV_W         12
`define DTL_LINK_W         16

// ----------------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------------
`define DTL_ADDR_DITHER    12'h09d
`define DTL_ADDR_LSB_CTRL  12'h160
`define DTL_ADDR_LINK_EN   12'h200
`define DTL_ADDR_CAL_CTRL  12'h300
`define DTL_ADDR_STATUS    12'h301

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define DTL_DITH_EN_BIT    0
`define DTL_DITH_AMP_BIT   1
`define DTL_DITH_ERR_BIT   2
`define DTL_TS_EN_BIT      0
`define DTL_LINK_EN_BIT    0
`define DTL_CAL_EN_BIT     0
`define DTL_RST_DITHER     8'h00
`define DTL_RST_LSB_CTRL   8'h00
`define DTL_RST_LINK_EN    8'h01
`define DTL_RST_CAL_CTRL   8'h00
`define DTL_ILA_CS         2'h0

// ----------------------------------------------------------------------------
// Timing: depth of the converter sample pipeline in mclk cycles
// ----------------------------------------------------------------------------
`define DTL_PIPE_DEPTH     8
`define DTL_PIPE_AW        3

`endif

// file: verilog/dtl_delay_mem.v
// Small circular delay memory that aligns the timestamp with the samples.
// Assumes the caller advances it one entry per enabled clock.
`timescale 1ns/1ps

module dtl_delay_mem #(
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire          mclk,
  input  wire          rst_b,
  input  wire          ce,
  input  wire          clr,
  input  wire [AW-1:0] ptr,
  input  wire          wr_bit,
  output reg           rd_bit_q
);

  reg [DEPTH-1:0] mem_q;

  // ----------------------------------------------------------------------------
  // Read old entry, then overwrite it: delay is DEPTH cycles
  // ----------------------------------------------------------------------------
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mem_q    <= {DEPTH{1'b0}};
      rd_bit_q <= 1'b0;
    end else if (ce) begin
      if (clr) begin
        mem_q    <= {DEPTH{1'b0}};
        rd_bit_q <= 1'b0;
      end else begin
        rd_bit_q   <= mem_q[ptr];
        mem_q[ptr] <= wr_bit;
      end
    end
  end

endmodule // dtl_delay_mem

// file: verilog/dtl_reg_bank.v
// Configuration register bank for dither, timestamp on sample LSB and
// serial link enable, plus the sample path that these controls steer.
// Assumes samples arrive one per mclk, synchronous, and that software
// follows the write order given below.
`timescale 1ns/1ps
`include "dtl_map.vh"

module dtl_reg_bank (
  input  wire                   mclk,
  input  wire                   rst_b,
  input  wire                   ce,
  // Register port
  input  wire [`DTL_AW-1:0]     reg_addr,
  input  wire [`DTL_DW-1:0]     reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [`DTL_DW-1:0]     reg_rdata_q,
  // Converter sample path
  input  wire [`DTL_CONV_W-1:0] conv_sample,
  input  wire [`DTL_CONV_W-1:0] dither_small,
  input  wire [`DTL_CONV_W-1:0] dither_large,
  input  wire                   single_channel_mode,
  input  wire                   timestamp_in,
  input  wire                   sysref_evt,
  output reg  [`DTL_CONV_W-1:0] core_dither_q,
  output reg  [`DTL_LINK_W-1:0] link_sample_q,
  // Control outputs
  output reg                    dither_enable_bit_q,
  output reg                    dither_amplitude_select_q,
  output reg                    rounding_error_select_q,
  output reg                    timestamp_on_lsb_enable_q,
  output reg                    link_rst_b_q,
  output reg                    serializer_pwr_q,
  output reg                    link_clk_en_q,
  output reg  [1:0]             ila_ctrl_bits_q,
  output reg  [7:0]             multiframe_counter_q
);

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  // Every register below holds still while ce is low, reads included, so a
  // frozen bank neither loses a stored value nor invents read data
  reg  [`DTL_DW-1:0]     dither_ctrl_q;
  reg  [`DTL_DW-1:0]     lsb_ctrl_q;
  reg  [`DTL_DW-1:0]     link_en_q;
  reg  [`DTL_DW-1:0]     cal_ctrl_q;
  reg  [`DTL_DW-1:0]     rdata_d;
  reg  [`DTL_PIPE_AW-1:0] ptr_q;
  reg  [`DTL_CONV_W-1:0] dith_pipe_q [0:`DTL_PIPE_DEPTH-1];
  reg  [`DTL_CONV_W-1:0] samp_pipe_q [0:`DTL_PIPE_DEPTH-1];
  reg  [`DTL_CONV_W-1:0] dith_sel;
  reg  [`DTL_CONV_W:0]   corrected_d;
  reg  [`DTL_CONV_W-1:0] clean_d;
  reg  [`DTL_LINK_W-1:0] link_d;
  wire                   ts_delayed;
  wire                   link_on;
  wire                   dith_on;
  wire [`DTL_CONV_W-1:0] last_samp;
  wire [`DTL_CONV_W-1:0] last_dith;
  reg  [`DTL_CONV_W-1:0] clean_q;
  wire [`DTL_CONV_W-1:0] trunc_d;
  wire [`DTL_CONV_W-1:0] noise_d;
  wire [`DTL_DW-1:0]     status_d;
  wire                   ts_on;
  wire                   mf_realign;

  // Field taps and pipeline ends used by the sample path
  assign link_on   = link_en_q[`DTL_LINK_EN_BIT];
  assign dith_on   = dither_ctrl_q[`DTL_DITH_EN_BIT];
  assign last_samp = samp_pipe_q[`DTL_PIPE_DEPTH-1];
  assign last_dith = dith_pipe_q[`DTL_PIPE_DEPTH-1];
  assign ts_on     = lsb_ctrl_q[`DTL_TS_EN_BIT];

  // SYSREF only realigns the multiframe counter while the link runs
  assign mf_realign = link_on & sysref_evt;

  // ----------------------------------------------------------------------------
  // Register writes; whole bytes stored so reserved bits read back as written
  // ----------------------------------------------------------------------------
  // Software owns the order of link enable against calibration enable and the
  // other link registers; each write is stored as it comes, so a wrong order
  // shows up on the link and not in this bank
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dither_ctrl_q <= `DTL_RST_DITHER;
      lsb_ctrl_q    <= `DTL_RST_LSB_CTRL;
      link_en_q     <= `DTL_RST_LINK_EN;
      cal_ctrl_q    <= `DTL_RST_CAL_CTRL;
    end else if (ce && reg_wr) begin
      case (reg_addr)
        `DTL_ADDR_DITHER:   dither_ctrl_q <= reg_wdata;
        `DTL_ADDR_LSB_CTRL: lsb_ctrl_q    <= reg_wdata;
        `DTL_ADDR_LINK_EN:  link_en_q     <= reg_wdata;
        `DTL_ADDR_CAL_CTRL: cal_ctrl_q    <= reg_wdata;
        default:            ;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Status word: live link controls, read only
  // ----------------------------------------------------------------------------
  assign status_d = {5'h00, link_clk_en_q, serializer_pwr_q, link_rst_b_q};

  // ----------------------------------------------------------------------------
  // Read mux; unmapped addresses read zero
  // ----------------------------------------------------------------------------
  always @* begin
    case (reg_addr)
      `DTL_ADDR_DITHER:   rdata_d = dither_ctrl_q;
      `DTL_ADDR_LSB_CTRL: rdata_d = lsb_ctrl_q;
      `DTL_ADDR_LINK_EN:  rdata_d = link_en_q;
      `DTL_ADDR_CAL_CTRL: rdata_d = cal_ctrl_q;
      `DTL_ADDR_STATUS:   rdata_d = status_d;
      default:            rdata_d = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_q <= 8'h00;
    end else if (ce) begin
      reg_rdata_q <= reg_rd ? rdata_d : 8'h00;
    end
  end

  // ----------------------------------------------------------------------------
  // Control outputs registered from the fields
  // ----------------------------------------------------------------------------
  // Dither field copies for the converter core
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dither_enable_bit_q       <= 1'b0;
      dither_amplitude_select_q <= 1'b0;
      rounding_error_select_q   <= 1'b0;
    end else if (ce) begin
      dither_enable_bit_q       <= dither_ctrl_q[`DTL_DITH_EN_BIT];
      dither_amplitude_select_q <= dither_ctrl_q[`DTL_DITH_AMP_BIT];
      rounding_error_select_q   <= dither_ctrl_q[`DTL_DITH_ERR_BIT];
    end
  end

  // Timestamp insertion flag for the transport layer
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      timestamp_on_lsb_enable_q <= 1'b0;
    end else if (ce) begin
      timestamp_on_lsb_enable_q <= ts_on;
    end
  end

  // Link reset, serializer power and clock gate all follow the enable bit;
  // they move together so a half-running link is never seen
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      link_rst_b_q              <= 1'b0;
      serializer_pwr_q          <= 1'b0;
      link_clk_en_q             <= 1'b0;
    end else if (ce) begin
      link_rst_b_q              <= link_on;
      serializer_pwr_q          <= link_on;
      link_clk_en_q             <= link_on;
    end
  end

  // Lane alignment data never advertises the stamp as a control bit
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ila_ctrl_bits_q           <= `DTL_ILA_CS;
    end else if (ce) begin
      ila_ctrl_bits_q           <= `DTL_ILA_CS;
    end
  end

  // ----------------------------------------------------------------------------
  // Dither injection into the core, with amplitude choice
  // ----------------------------------------------------------------------------
  // Amplitude is taken from the field itself, so the core dither and the
  // registered copy on the pin change on the same edge
  always @* begin
    if (dither_ctrl_q[`DTL_DITH_AMP_BIT])
      dith_sel = dither_large;
    else
      dith_sel = dither_small;
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      core_dither_q <= 12'h000;
    end else if (ce) begin
      core_dither_q <= dith_on ? dith_sel : 12'h000;
    end
  end

  // ----------------------------------------------------------------------------
  // Sample and dither pipeline, one stage per entry, stage 0 outside the generate
  // ----------------------------------------------------------------------------
  // Stage 0 takes the fresh sample beside the dither that went into it
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      samp_pipe_q[0] <= 12'h000;
      dith_pipe_q[0] <= 12'h000;
    end else if (ce) begin
      samp_pipe_q[0] <= conv_sample;
      dith_pipe_q[0] <= core_dither_q;
    end
  end

  // Remaining stages shift one entry per enabled clock
  genvar gi;
  generate
    for (gi = 1; gi < `DTL_PIPE_DEPTH; gi = gi + 1) begin : g_pipe
      always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          samp_pipe_q[gi] <= 12'h000;
          dith_pipe_q[gi] <= 12'h000;
        end else if (ce) begin
          samp_pipe_q[gi] <= samp_pipe_q[gi-1];
          dith_pipe_q[gi] <= dith_pipe_q[gi-1];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Dither subtraction with selectable rounding
  // ----------------------------------------------------------------------------
  // Raw difference with a guard bit so the borrow stays out of the result
  always @* begin
    corrected_d = {1'b0, last_samp} - {1'b0, last_dith};
  end

  // Fixed truncation: error lands as offset and rate-related spurs
  assign trunc_d = {corrected_d[`DTL_CONV_W-1:1], 1'b0};
  // Residual dither LSB folded back in single channel mode so error spreads as noise
  assign noise_d = corrected_d[`DTL_CONV_W-1:0] ^
                   {{(`DTL_CONV_W-1){1'b0}}, last_dith[0] & single_channel_mode};

  // Pick the corrected sample for the chosen rounding
  always @* begin
    if (!dith_on)
      clean_d = last_samp;
    else if (dither_ctrl_q[`DTL_DITH_ERR_BIT])
      clean_d = trunc_d;
    else
      clean_d = noise_d;
  end

  // Corrected sample registered so it leaves beside the stamp memory's read register
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      clean_q <= 12'h000;
    end else if (ce) begin
      clean_q <= clean_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Timestamp delay, matched to the sample pipeline depth
  // ----------------------------------------------------------------------------
  // The memory is as deep as the sample pipe; its read register stands in for
  // the corrected-sample register, so stamp and sample leave on one edge
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_q <= 3'h0;
    end else if (ce) begin
      ptr_q <= ptr_q + 3'h1;
    end
  end

  dtl_delay_mem #(
    .DEPTH (`DTL_PIPE_DEPTH),
    .AW    (`DTL_PIPE_AW)
  ) u_ts_delay (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .ce       (ce),
    .clr      (1'b0),
    .ptr      (ptr_q),
    .wr_bit   (timestamp_in),
    .rd_bit_q (ts_delayed)
  );

  // ----------------------------------------------------------------------------
  // Link sample packing: converter bits at the top, timestamp in the LSB
  // ----------------------------------------------------------------------------
  always @* begin
    link_d = {clean_q, {(`DTL_LINK_W-`DTL_CONV_W){1'b0}}};
    if (ts_on)
      link_d[0] = ts_delayed;
  end

  // All zero while the link is off, as its serializers are down
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      link_sample_q <= 16'h0000;
    end else if (ce) begin
      link_sample_q <= link_on ? link_d : 16'h0000;
    end
  end

  // ----------------------------------------------------------------------------
  // Multiframe counter: held in reset while the link is off
  // ----------------------------------------------------------------------------
  // Counts every enabled cycle; SYSREF while running pulls it back to zero
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      multiframe_counter_q <= 8'h00;
    end else if (ce) begin
      if (!link_on)
        multiframe_counter_q <= 8'h00;
      else if (mf_realign)
        multiframe_counter_q <= 8'h00;
      else
        multiframe_counter_q <= multiframe_counter_q + 8'h01;
    end
  end

endmodule // dtl_reg_bank

// file: tb/dtl_reg_bank_asserts.sv
// Checker for the dither, timestamp and link enable register bank.
// Assumes the bench keeps ce high while the sample path is checked.
`timescale 1ns/1ps
`include "dtl_map.vh"

module dtl_reg_bank_chk (
  input wire                   mclk,
  input wire                   rst_b,
  input wire                   ce,
  input wire                   reg_rd,
  input wire [`DTL_DW-1:0]     reg_rdata_q,
  input wire [`DTL_CONV_W-1:0] conv_sample,
  input wire [`DTL_CONV_W-1:0] dither_small,
  input wire [`DTL_CONV_W-1:0] dither_large,
  input wire                   timestamp_in,
  input wire [`DTL_CONV_W-1:0] core_dither_q,
  input wire [`DTL_LINK_W-1:0] link_sample_q,
  input wire                   dither_enable_bit_q,
  input wire                   dither_amplitude_select_q,
  input wire                   timestamp_on_lsb_enable_q,
  input wire                   link_rst_b_q,
  input wire                   serializer_pwr_q,
  input wire                   link_clk_en_q,
  input wire [1:0]             ila_ctrl_bits_q,
  input wire [7:0]             multiframe_counter_q
);
  // --------------------------------------------------------------------------
  // Settle counter: cycles with link on, stamp on, dither off
  // --------------------------------------------------------------------------
  reg [3:0] settle_q;
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b)
      settle_q <= 4'h0;
    else if (!(ce && link_rst_b_q && timestamp_on_lsb_enable_q && !dither_enable_bit_q))
      settle_q <= 4'h0;
    else if (settle_q != 4'hf)
      settle_q <= settle_q + 4'h1;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  chk_rdata_idle: assert property ($past(ce) && !$past(reg_rd) |-> reg_rdata_q == 8'h00)
    else $error("read data not idle");
  chk_link_gate: assert property (serializer_pwr_q == link_rst_b_q && link_clk_en_q == link_rst_b_q)
    else $error("link controls disagree");
  chk_mf_held: assert property (!link_rst_b_q |-> multiframe_counter_q == 8'h00)
    else $error("multiframe counter runs while off");
  chk_ila_cs: assert property (ila_ctrl_bits_q == `DTL_ILA_CS)
    else $error("control bit count advertised");
  chk_dither_off: assert property ($past(ce) && !dither_enable_bit_q && !$past(dither_enable_bit_q) |-> core_dither_q == 12'h000)
    else $error("dither while disabled");
  chk_dither_amp: assert property ($past(ce) && dither_enable_bit_q && $stable(dither_enable_bit_q) && $stable(dither_amplitude_select_q)
    |-> core_dither_q == (dither_amplitude_select_q ? $past(dither_large) : $past(dither_small)))
    else $error("wrong dither amplitude");
  chk_pad_zero: assert property (link_sample_q[3:1] == 3'h0)
    else $error("pad bits not zero");
  chk_path_latency: assert property (settle_q >= 4'hc |-> link_sample_q == {$past(conv_sample, 10), 3'h0, $past(timestamp_in, 10)})
    else $error("sample or stamp latency wrong");

  // Main scenarios reached
  cov_read: cover property (reg_rd ##1 reg_rdata_q != 8'h00);
  cov_link_off: cover property ($fell(link_rst_b_q));
  cov_stamp: cover property (settle_q >= 4'hc && link_sample_q[0]);
endmodule // dtl_reg_bank_chk

bind dtl_reg_bank dtl_reg_bank_chk chk_i (.mclk, .rst_b, .ce, .reg_rd, .reg_rdata_q, .conv_sample,
  .dither_small, .dither_large, .timestamp_in, .core_dither_q, .link_sample_q,
  .dither_enable_bit_q, .dither_amplitude_select_q, .timestamp_on_lsb_enable_q, .link_rst_b_q,
  .serializer_pwr_q, .link_clk_en_q, .ila_ctrl_bits_q, .multiframe_counter_q);

// file: tb/dtl_reg_bank_tb.sv
// Self-checking bench for the dither, timestamp and link enable register bank.
// Assumes the bank answers reads one cycle later and ce may stay high.
`timescale 1ns/1ps
`include "dtl_map.vh"

module dtl_reg_bank_tb;
  reg         mclk, rst_b, ce, scm, reg_wr, reg_rd, ts_in, sysref;
  reg  [11:0] addr, conv, dsm, dlg;
  reg  [7:0]  wdata;
  wire [7:0]  rdata, mfc;
  wire [11:0] cdith;
  wire [15:0] lsamp;
  wire        den, damp, derr, tsen, lrst, spwr, lclk;
  wire [1:0]  ila;
  integer     n_mismatch, num_checks, k;

  dtl_reg_bank uut (.mclk(mclk), .rst_b(rst_b), .ce(ce), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(rdata), .conv_sample(conv),
    .dither_small(dsm), .dither_large(dlg), .single_channel_mode(scm), .timestamp_in(ts_in),
    .sysref_evt(sysref), .core_dither_q(cdith), .link_sample_q(lsamp),
    .dither_enable_bit_q(den), .dither_amplitude_select_q(damp),
    .rounding_error_select_q(derr), .timestamp_on_lsb_enable_q(tsen), .link_rst_b_q(lrst),
    .serializer_pwr_q(spwr), .link_clk_en_q(lclk), .ila_ctrl_bits_q(ila),
    .multiframe_counter_q(mfc));

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  always #5 mclk = ~mclk;

  task check(input ok, input [8*20-1:0] msg); begin
    num_checks = num_checks + 1;
    if (ok !== 1'b1) begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0t %0s", $time, msg);
    end
  end endtask

  task conclude; begin
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end endtask

  task wr(input [11:0] a, input [7:0] d); begin
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  end endtask

  task rd(input [11:0] a, input [7:0] e); begin
    @(posedge mclk);
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 check(rdata === e, "read data");
  end endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task t_reset; begin
    rd(`DTL_ADDR_DITHER, `DTL_RST_DITHER);
    rd(`DTL_ADDR_LSB_CTRL, `DTL_RST_LSB_CTRL);
    rd(`DTL_ADDR_LINK_EN, `DTL_RST_LINK_EN);
    check({lrst, spwr, lclk} === 3'h7, "link not up");
    wr(12'h123, 8'h5a);
    rd(12'h123, 8'h00);
  end endtask

  task t_dither; begin
    wr(`DTL_ADDR_DITHER, 8'h07);
    rd(`DTL_ADDR_DITHER, 8'h07);
    check({den, damp, derr} === 3'h7, "field copies");
    wr(`DTL_ADDR_DITHER, 8'h01);
    repeat (2) @(posedge mclk);
    #1 check(cdith === dsm, "small dither");
    wr(`DTL_ADDR_DITHER, 8'h03);
    repeat (2) @(posedge mclk);
    #1 check(cdith === dlg, "large dither");
    repeat (12) @(posedge mclk);
    #1 check(lsamp[15:4] === conv - dlg, "noise rounding");
    @(posedge mclk);
    scm <= 1'b1;
    wr(`DTL_ADDR_DITHER, 8'h01);
    repeat (12) @(posedge mclk);
    #1 check(lsamp[15:4] === ((conv - dsm) ^ 12'h001), "single channel");
    wr(`DTL_ADDR_DITHER, 8'h07);
    scm <= 1'b0;
    repeat (12) @(posedge mclk);
    #1 check(lsamp[4] === 1'b0, "offset rounding");
    wr(`DTL_ADDR_DITHER, 8'h00);
    repeat (12) @(posedge mclk);
    #1 check(lsamp === {conv, 4'h0}, "clean sample");
  end endtask

  task t_stamp; begin
    wr(`DTL_ADDR_LSB_CTRL, 8'h01);
    repeat (12) @(posedge mclk);
    ts_in <= 1'b1;
    conv <= 12'habc;
    @(posedge mclk);
    ts_in <= 1'b0;
    conv <= 12'h567;
    k = 1;
    while (k < 20 && lsamp[0] !== 1'b1) begin
      @(posedge mclk);
      #1 k = k + 1;
    end
    check(k == 10, "stamp latency");
    check(lsamp === {12'habc, 4'h1}, "stamp in lsb");
    if (k >= 20)
      conclude;
    wr(`DTL_ADDR_LSB_CTRL, 8'h00);
  end endtask

  task t_link; begin
    wr(`DTL_ADDR_CAL_CTRL, 8'h01);
    wr(`DTL_ADDR_LINK_EN, 8'h00);
    sysref <= 1'b1;
    @(posedge mclk);
    sysref <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 check({lrst, spwr, lclk} === 3'h0, "link not down");
    check(mfc === 8'h00 && lsamp === 16'h0000, "held in reset");
    rd(`DTL_ADDR_LINK_EN, 8'h00);
    rd(`DTL_ADDR_STATUS, 8'h00);
    wr(`DTL_ADDR_LINK_EN, 8'h01);
    repeat (2) @(posedge mclk);
    #1 check({lrst, spwr, lclk} === 3'h7, "link not up");
    rd(`DTL_ADDR_STATUS, 8'h07);
    @(posedge mclk);
    sysref <= 1'b1;
    @(posedge mclk);
    sysref <= 1'b0;
    #1 check(mfc === 8'h00, "sysref realign");
    @(posedge mclk);
    #1 check(mfc === 8'h01, "counter runs");
    wr(`DTL_ADDR_LINK_EN, 8'h00);
    wr(`DTL_ADDR_CAL_CTRL, 8'h00);
    rd(`DTL_ADDR_CAL_CTRL, 8'h00);
  end endtask

  task t_freeze; begin
    @(posedge mclk);
    ce <= 1'b0;
    wr(`DTL_ADDR_DITHER, 8'h02);
    ce <= 1'b1;
    rd(`DTL_ADDR_DITHER, 8'h00);
  end endtask

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    n_mismatch = 0;
    num_checks = 0;
    mclk = 1'b0;
    rst_b = 1'b0;
    {reg_wr, reg_rd, ts_in, sysref} = 4'h0;
    ce = 1'b1;
    scm = 1'b0;
    addr = 12'h000;
    wdata = 8'h00;
    conv = 12'h567;
    dsm = 12'h011;
    dlg = 12'h0f0;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset;
    t_dither;
    t_stamp;
    t_link;
    t_freeze;
    conclude;
  end
endmodule // dtl_reg_bank_tb
